// ### include/intc_map.vh
// Constants for the interrupt flag routing unit
`ifndef INTC_MAP_VH
`define INTC_MAP_VH

// ********************************************************
// Source count and storage width
// ********************************************************
`define IFR_NSRC        41
`define IFR_NBYTE       6
`define IFR_NBIT        48
`define IFR_NPIN        12

// ********************************************************
// Write kinds on the software port
// ********************************************************
`define IFR_K_REQ       3'h0
`define IFR_K_MASK      3'h1
`define IFR_K_PRLO      3'h2
`define IFR_K_PRHI      3'h3
`define IFR_K_RISE      3'h4
`define IFR_K_FALL      3'h5

// ********************************************************
// Reset values
// ********************************************************
`define IFR_REQ_RST     48'h0000_0000_0000
`define IFR_MASK_RST    48'hffff_ffff_ffff
`define IFR_PRIO_RST    48'hffff_ffff_ffff
`define IFR_EDGE_RST    16'h0000

// ********************************************************
// Flag positions of shared and pin sources
// ********************************************************
`define IFR_BIT_CH0_TX  13
`define IFR_BIT_CH0_RX  14
`define IFR_BIT_CH1_TX  16
`define IFR_BIT_CH2_TX  28
`define IFR_PIN_LO_BASE 2
`define IFR_PIN_HI_BASE 35
`define IFR_PIN_LO_CNT  6

`endif

// ### rtl/interrupt_flag_routing.v
// Interrupt request, mask, priority and edge-enable flag unit
`timescale 1ns/100ps
`include "intc_map.vh"

module interrupt_flag_routing #(
  parameter NSRC = `IFR_NSRC,
  parameter NPIN = `IFR_NPIN
) (
  // Clock and reset
  input  wire                  core_clk_i,
  input  wire                  rst_i,
  // Peripheral events, one pulse per flag position
  input  wire [NSRC-1:0]       periph_evt_i,
  input  wire                  clocked_serial_unit_00_done_i,
  input  wire                  clocked_serial_unit_01_done_i,
  input  wire                  clocked_serial_unit_10_done_i,
  input  wire                  two_wire_unit_10_done_i,
  input  wire                  clocked_serial_unit_20_done_i,
  input  wire                  two_wire_unit_20_done_i,
  // External interrupt pins
  input  wire [NPIN-1:0]       ext_pin_i,
  // Software register port
  input  wire                  sw_wr_i,
  input  wire [2:0]            sw_kind_i,
  input  wire [2:0]            sw_sel_i,
  input  wire [7:0]            sw_data_i,
  output reg  [7:0]            sw_rdata_o,
  // Processor status word gate
  input  wire                  psw_ie_i,
  // Processor side
  input  wire                  irq_ack_i,
  output reg                   irq_req_o,
  output reg  [5:0]            irq_idx_o,
  output reg  [1:0]            irq_level_o
);

  // ********************************************************
  // Storage
  // ********************************************************
  reg  [`IFR_NBIT-1:0] req_ff;
  reg  [`IFR_NBIT-1:0] mask_ff;
  reg  [`IFR_NBIT-1:0] prlo_ff;
  reg  [`IFR_NBIT-1:0] prhi_ff;
  reg  [15:0]          rise_ff;
  reg  [15:0]          fall_ff;
  reg  [NPIN-1:0]      pin_ff;
  reg  [`IFR_NBIT-1:0] nxt_req;
  reg  [`IFR_NBIT-1:0] nxt_mask;
  reg  [`IFR_NBIT-1:0] nxt_prlo;
  reg  [`IFR_NBIT-1:0] nxt_prhi;
  reg  [`IFR_NBIT-1:0] hw_set;
  reg  [`IFR_NBIT-1:0] ack_clr;
  reg  [7:0]           nxt_rdata;

  wire [NPIN-1:0]      pin_edge;
  wire [`IFR_NBIT-1:0] byte_sel;
  wire [`IFR_NBIT-1:0] wr_data;
  wire                 sel_ok;
  wire                 win_valid;
  wire [5:0]           win_idx;
  wire [1:0]           win_level;
  integer              p;

  // Byte lane mask for one of the six 8-bit flag registers
  function [`IFR_NBIT-1:0] lane;
    input [2:0] sel;
    begin
      lane = {{(`IFR_NBIT-8){1'b0}}, 8'hff} << {sel, 3'h0};
    end
  endfunction

  assign sel_ok   = (sw_sel_i < `IFR_NBYTE);
  assign byte_sel = sel_ok ? lane(sw_sel_i) : {`IFR_NBIT{1'b0}};
  assign wr_data  = {`IFR_NBYTE{sw_data_i}};

  // ********************************************************
  // Pin edge detection
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      assign pin_edge[g] = (ext_pin_i[g] & ~pin_ff[g] & rise_ff[g]) |
                           (~ext_pin_i[g] & pin_ff[g] & fall_ff[g]);
    end
  endgenerate

  // ********************************************************
  // Hardware set sources
  // ********************************************************
  always @* begin
    hw_set = {`IFR_NBIT{1'b0}};
    hw_set[NSRC-1:0] = periph_evt_i;
    hw_set[`IFR_BIT_CH0_TX] = periph_evt_i[`IFR_BIT_CH0_TX] |
                              clocked_serial_unit_00_done_i;
    hw_set[`IFR_BIT_CH0_RX] = periph_evt_i[`IFR_BIT_CH0_RX] |
                              clocked_serial_unit_01_done_i;
    hw_set[`IFR_BIT_CH1_TX] = periph_evt_i[`IFR_BIT_CH1_TX] |
                              clocked_serial_unit_10_done_i |
                              two_wire_unit_10_done_i;
    hw_set[`IFR_BIT_CH2_TX] = periph_evt_i[`IFR_BIT_CH2_TX] |
                              clocked_serial_unit_20_done_i |
                              two_wire_unit_20_done_i;
    // Pin flags follow only the edge detector, not the event vector
    for (p = 0; p < NPIN; p = p + 1) begin
      if (p < `IFR_PIN_LO_CNT) begin
        hw_set[`IFR_PIN_LO_BASE + p] = pin_edge[p];
      end else begin
        hw_set[`IFR_PIN_HI_BASE + p - `IFR_PIN_LO_CNT] = pin_edge[p];
      end
    end
  end

  // ********************************************************
  // Next-state of flag banks
  // ********************************************************
  always @* begin
    ack_clr = {`IFR_NBIT{1'b0}};
    if (irq_ack_i && irq_req_o) begin
      ack_clr[irq_idx_o] = 1'b1;
    end
    nxt_req  = req_ff & ~ack_clr;
    nxt_mask = mask_ff;
    nxt_prlo = prlo_ff;
    nxt_prhi = prhi_ff;
    if (sw_wr_i) begin
      case (sw_kind_i)
        `IFR_K_REQ:  nxt_req  = (nxt_req & ~byte_sel) | (wr_data & byte_sel);
        `IFR_K_MASK: nxt_mask = (mask_ff & ~byte_sel) | (wr_data & byte_sel);
        `IFR_K_PRLO: nxt_prlo = (prlo_ff & ~byte_sel) | (wr_data & byte_sel);
        `IFR_K_PRHI: nxt_prhi = (prhi_ff & ~byte_sel) | (wr_data & byte_sel);
        default: begin
        end
      endcase
    end
    // A source event in the clearing cycle still lands
    nxt_req = nxt_req | hw_set;
    // Bits above the last source read back as zero
    nxt_req[`IFR_NBIT-1:NSRC] = {(`IFR_NBIT-NSRC){1'b0}};
  end

  // Read back the selected register
  always @* begin
    nxt_rdata = 8'h00;
    if (sel_ok) begin
      case (sw_kind_i)
        `IFR_K_REQ:  nxt_rdata = req_ff[{sw_sel_i, 3'h0} +: 8];
        `IFR_K_MASK: nxt_rdata = mask_ff[{sw_sel_i, 3'h0} +: 8];
        `IFR_K_PRLO: nxt_rdata = prlo_ff[{sw_sel_i, 3'h0} +: 8];
        `IFR_K_PRHI: nxt_rdata = prhi_ff[{sw_sel_i, 3'h0} +: 8];
        `IFR_K_RISE: nxt_rdata = (sw_sel_i == 3'h0) ? rise_ff[7:0] :
                                 (sw_sel_i == 3'h1) ? rise_ff[15:8] : 8'h00;
        `IFR_K_FALL: nxt_rdata = (sw_sel_i == 3'h0) ? fall_ff[7:0] :
                                 (sw_sel_i == 3'h1) ? fall_ff[15:8] : 8'h00;
        default:     nxt_rdata = 8'h00;
      endcase
    end
  end

  // ********************************************************
  // Arbitration
  // ********************************************************
  prio_select #(
    .NSRC    (NSRC)
  ) u_prio_select (
    .pend_i  (req_ff[NSRC-1:0] & ~mask_ff[NSRC-1:0]),
    .prlo_i  (prlo_ff[NSRC-1:0]),
    .prhi_i  (prhi_ff[NSRC-1:0]),
    .valid_o (win_valid),
    .idx_o   (win_idx),
    .level_o (win_level)
  );

  // ********************************************************
  // Registers
  // ********************************************************
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      req_ff      <= `IFR_REQ_RST;
      mask_ff     <= `IFR_MASK_RST;
      prlo_ff     <= `IFR_PRIO_RST;
      prhi_ff     <= `IFR_PRIO_RST;
      rise_ff     <= `IFR_EDGE_RST;
      fall_ff     <= `IFR_EDGE_RST;
      pin_ff      <= {NPIN{1'b0}};
      sw_rdata_o  <= 8'h00;
      irq_req_o   <= 1'b0;
      irq_idx_o   <= 6'h00;
      irq_level_o <= 2'h3;
    end else begin
      req_ff     <= nxt_req;
      mask_ff    <= nxt_mask;
      prlo_ff    <= nxt_prlo;
      prhi_ff    <= nxt_prhi;
      pin_ff     <= ext_pin_i;
      sw_rdata_o <= nxt_rdata;
      if (sw_wr_i && (sw_kind_i == `IFR_K_RISE) && (sw_sel_i[2:1] == 2'h0)) begin
        rise_ff[{sw_sel_i[0], 3'h0} +: 8] <= sw_data_i;
      end
      if (sw_wr_i && (sw_kind_i == `IFR_K_FALL) && (sw_sel_i[2:1] == 2'h0)) begin
        fall_ff[{sw_sel_i[0], 3'h0} +: 8] <= sw_data_i;
      end
      // Held off during the acknowledge cycle so the same flag is not offered twice
      irq_req_o   <= win_valid & psw_ie_i & ~(irq_ack_i & irq_req_o);
      irq_idx_o   <= win_idx;
      irq_level_o <= win_level;
    end
  end

endmodule // interrupt_flag_routing

// ### rtl/prio_select.v
// Priority selector: two-bit level first, then fixed default rank
`timescale 1ns/100ps
`include "intc_map.vh"

module prio_select #(
  parameter NSRC = `IFR_NSRC
) (
  // Candidates
  input  wire [NSRC-1:0]   pend_i,
  input  wire [NSRC-1:0]   prlo_i,
  input  wire [NSRC-1:0]   prhi_i,
  // Winner
  output reg               valid_o,
  output reg  [5:0]        idx_o,
  output reg  [1:0]        level_o
);

  integer i;

  // Walk from lowest rank up so that on equal level the lower index wins
  always @* begin
    valid_o = 1'b0;
    idx_o   = 6'h00;
    level_o = 2'h3;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (pend_i[i] && ({prhi_i[i], prlo_i[i]} <= level_o)) begin
        valid_o = 1'b1;
        idx_o   = i[5:0];
        level_o = {prhi_i[i], prlo_i[i]};
      end
    end
  end

endmodule // prio_select

// ### tb/core_ack_model.sv
// Processor core stand-in that acknowledges presented requests
`timescale 1ns/100ps
module core_ack_model (
  // Control
  input  wire       core_clk_i,
  input  wire       en_i,
  input  wire [3:0] dly_i,
  // Unit side
  input  wire       req_i,
  input  wire [5:0] idx_i,
  input  wire [1:0] level_i,
  output reg        ack_o = 1'b0,
  // Record of the last acknowledge
  output reg  [7:0] cnt_o = 8'h00,
  output reg  [5:0] idx_o = 6'h00,
  output reg  [1:0] level_o = 2'h0
);
  reg [3:0] wait_ff = 4'h0;
  // One-cycle ack pulse, then it waits for the re-arbitrated request
  always @(negedge core_clk_i) begin
    if (ack_o || !en_i || !req_i) begin
      ack_o <= 1'b0;
      wait_ff <= 4'h0;
    end else if (wait_ff == dly_i) begin
      ack_o <= 1'b1;
      idx_o <= idx_i;
      level_o <= level_i;
      cnt_o <= cnt_o + 8'h01;
    end else
      wait_ff <= wait_ff + 4'h1;
  end
endmodule // core_ack_model

// ### tb/interrupt_flag_routing_assertions.sv
// Checker for the interrupt flag routing unit
`timescale 1ns/100ps
module ifr_checker (
  input wire       core_clk_i,
  input wire       rst_i,
  input wire       psw_ie_i,
  input wire       irq_ack_i,
  input wire       irq_req_o,
  input wire [5:0] irq_idx_o,
  input wire [1:0] irq_level_o,
  input wire       sw_wr_i,
  input wire [2:0] sw_kind_i,
  input wire [2:0] sw_sel_i,
  input wire [7:0] sw_data_i,
  input wire [7:0] sw_rdata_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_ie_gates_req: assert property (!psw_ie_i |=> !irq_req_o) else $error("req without ie");
  a_ack_drops_req: assert property (irq_ack_i && irq_req_o |=> !irq_req_o)
    else $error("req held after ack");
  a_reset_outs: assert property (disable iff (1'b0) rst_i |=> !irq_req_o && irq_idx_o == 6'h00
    && irq_level_o == 2'h3 && sw_rdata_o == 8'h00) else $error("bad reset outputs");
  a_mask_rst_read: assert property (disable iff (1'b0) rst_i ##1 (!rst_i && !sw_wr_i
    && sw_kind_i != 3'h0 && sw_kind_i < 3'h4 && sw_sel_i < 3'h6) |=> sw_rdata_o == 8'hff)
    else $error("mask or prio not ones after reset");
  a_unmapped_zero: assert property (sw_sel_i > 3'h5 || sw_kind_i > 3'h5 |=> sw_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_edge_sel_zero: assert property (sw_kind_i > 3'h3 && sw_sel_i > 3'h1 |=> sw_rdata_o == 8'h00)
    else $error("edge enable unmapped read not zero");
  a_top_group_zero: assert property (sw_kind_i == 3'h0 && sw_sel_i == 3'h5
    |=> sw_rdata_o[7:1] == 7'h00) else $error("unused request bits read set");
  a_idx_in_range: assert property (irq_req_o |-> irq_idx_o <= 6'd40) else $error("idx beyond 40");
  a_write_reads_back: assert property (sw_wr_i && sw_kind_i != 3'h0 && sw_kind_i < 3'h6
    && sw_sel_i < (sw_kind_i > 3'h3 ? 3'h2 : 3'h6) ##1 !sw_wr_i && $stable({sw_kind_i, sw_sel_i})
    |=> sw_rdata_o == $past(sw_data_i, 2)) else $error("write not read back");
  c_ack: cover property (irq_ack_i && irq_req_o);
  c_level1: cover property (irq_req_o && irq_level_o == 2'h1);
  c_unmapped: cover property (sw_sel_i == 3'h6);
endmodule // ifr_checker

bind interrupt_flag_routing ifr_checker ifr_checker_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .psw_ie_i(psw_ie_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_idx_o(irq_idx_o),
  .irq_level_o(irq_level_o), .sw_wr_i(sw_wr_i), .sw_kind_i(sw_kind_i), .sw_sel_i(sw_sel_i),
  .sw_data_i(sw_data_i), .sw_rdata_o(sw_rdata_o));

// ### tb/interrupt_flag_routing_tb.sv
// Self-checking bench for the interrupt flag routing unit
`timescale 1ns/100ps
module interrupt_flag_routing_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [40:0] evt = 41'h0;
  reg  [5:0]  done = 6'h00;
  reg  [11:0] pin = 12'h000;
  reg         wr = 1'b0;
  reg  [2:0]  kind = 3'h1;
  reg  [2:0]  sel = 3'h0;
  reg  [7:0]  data = 8'h00;
  reg         ie = 1'b0;
  reg         men = 1'b0;
  reg  [3:0]  mdly = 4'h0;
  reg  [47:0] tab = 48'h10_10_01_01_40_20;
  wire [7:0]  rdata, cnt;
  wire        ack, req;
  wire [5:0]  idx, gidx;
  wire [1:0]  lvl, glvl;
  integer     err_count = 0;
  integer     n_tests = 0;
  integer     k;
  initial forever #5 clk = ~clk;
  interrupt_flag_routing interrupt_flag_routing_i (.core_clk_i(clk), .rst_i(rst),
    .periph_evt_i(evt), .clocked_serial_unit_00_done_i(done[0]),
    .clocked_serial_unit_01_done_i(done[1]), .clocked_serial_unit_10_done_i(done[2]),
    .two_wire_unit_10_done_i(done[3]), .clocked_serial_unit_20_done_i(done[4]),
    .two_wire_unit_20_done_i(done[5]), .ext_pin_i(pin), .sw_wr_i(wr), .sw_kind_i(kind),
    .sw_sel_i(sel), .sw_data_i(data), .sw_rdata_o(rdata), .psw_ie_i(ie), .irq_ack_i(ack),
    .irq_req_o(req), .irq_idx_o(idx), .irq_level_o(lvl));
  core_ack_model core_ack_model_i (.core_clk_i(clk), .en_i(men), .dly_i(mdly), .req_i(req),
    .idx_i(idx), .level_i(lvl), .ack_o(ack), .cnt_o(cnt), .idx_o(gidx), .level_o(glvl));
  task check(input [8*8-1:0] what, input [47:0] seen, input [47:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd(input [2:0] k_v, input [2:0] s_v, input [7:0] exp);
    begin
      @(negedge clk) {kind, sel} = {k_v, s_v};
      repeat (2) @(negedge clk);
      check("rdata", rdata, exp);
    end
  endtask
  task wr_rd(input [2:0] k_v, input [2:0] s_v, input [7:0] d, input [7:0] exp);
    begin
      @(negedge clk) {wr, kind, sel, data} = {1'b1, k_v, s_v, d};
      @(negedge clk) wr = 1'b0;
      rd(k_v, s_v, exp);
    end
  endtask
  task ev(input [40:0] e, input [5:0] d);
    begin
      @(negedge clk) {evt, done} = {e, d};
      @(negedge clk) {evt, done} = 47'h0;
    end
  endtask
  task got(input [7:0] n, input [5:0] i, input [1:0] l);
    begin
      for (k = 0; k < 40 && cnt !== n; k = k + 1) @(negedge clk);
      check("ack rec", {cnt, gidx, glvl}, {n, i, l});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #100000 err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 6; k = k + 1) begin
      rd(3'h0, k[2:0], 8'h00);
      rd(3'h3, k[2:0], 8'hff);
      rd(3'h1, k[2:0], 8'hff);
    end
    $display("reset test done");
    wr_rd(3'h2, 3'h4, 8'h5a, 8'h5a);
    wr_rd(3'h5, 3'h1, 8'h0f, 8'h0f);
    wr_rd(3'h4, 3'h2, 8'hff, 8'h00);
    wr_rd(3'h0, 3'h5, 8'hfe, 8'h00);
    wr_rd(3'h1, 3'h6, 8'h00, 8'h00);
    $display("register test done");
    for (k = 0; k < 6; k = k + 1) begin
      ev(41'h0, 6'h01 << k);
      rd(3'h0, k[3:1] + 3'h1, tab[8*k +: 8]);
      wr_rd(3'h0, k[3:1] + 3'h1, 8'h00, 8'h00);
    end
    $display("shared source test done");
    wr_rd(3'h4, 3'h0, 8'h01, 8'h01);
    @(negedge clk) pin = 12'h801;
    rd(3'h0, 3'h0, 8'h04);
    rd(3'h0, 3'h5, 8'h00);
    @(negedge clk) pin = 12'h001;
    rd(3'h0, 3'h5, 8'h01);
    wr_rd(3'h0, 3'h0, 8'h00, 8'h00);
    wr_rd(3'h0, 3'h5, 8'h00, 8'h00);
    $display("pin test done");
    wr_rd(3'h1, 3'h1, 8'h00, 8'h00);
    wr_rd(3'h1, 3'h2, 8'h00, 8'h00);
    wr_rd(3'h3, 3'h2, 8'h00, 8'h00);
    ev((41'h1 << 20) | (41'h1 << 9) | (41'h1 << 30), 6'h00);
    repeat (3) @(negedge clk);
    check("req", req, 1'b0);
    ie = 1'b1;
    repeat (3) @(negedge clk);
    check("winner", {req, idx, lvl}, {1'b1, 6'd20, 2'h1});
    men = 1'b1;
    got(8'h01, 6'd20, 2'h1);
    got(8'h02, 6'd9, 2'h3);
    ev((41'h1 << 12) | (41'h1 << 10), 6'h00);
    got(8'h03, 6'd10, 2'h3);
    mdly = 4'h5;
    got(8'h04, 6'd12, 2'h3);
    repeat (10) @(negedge clk);
    check("idle", {req, cnt}, {1'b0, 8'h04});
    rd(3'h0, 3'h1, 8'h00);
    $display("arbitration test done");
    // Reset in mid-run with a request standing; core stand-in kept quiet
    men = 1'b0;
    ev(41'h1 << 11, 6'h00);
    repeat (2) @(negedge clk);
    check("req", req, 1'b1);
    @(negedge clk) {rst, kind, sel} = {1'b1, 3'h1, 3'h1};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("req rst", req, 1'b0);
    rd(3'h1, 3'h1, 8'hff);
    rd(3'h0, 3'h1, 8'h00);
    $display("reset rerun test done");
    print_verdict;
  end
endmodule // interrupt_flag_routing_tb
